/* File: rtl/rail_power_good_ctrl.sv */
// rail limit tracking, power-good status, low limit masking and general input handling
`timescale 1ns/100ps
`default_nettype none

module rail_power_good_ctrl
  import rail_pg_pkg::*;
#(
  parameter int unsigned P_STEP_CYCLES = STEP_CYCLES
)
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wr_data,
  input wire logic i_wr_strobe,
  input wire logic i_rd_strobe,
  output logic [DATA_W-1:0] o_rd_data,
  input wire logic [NUM_RAILS*MV_W-1:0] i_sense_mv,
  input wire logic [NUM_RAILS-1:0] i_rail_on,
  input wire logic [NUM_RAILS-1:0] i_turn_on_met,
  input wire logic [NUM_RAILS-1:0] i_turn_off_met,
  input wire logic [NUM_RAILS-1:0] i_fault_off,
  input wire logic [NUM_GPI-1:0] i_general_input_pin,
  output logic [NUM_RAILS-1:0] o_power_good,
  output logic [NUM_RAILS-1:0] o_low_limit_mask,
  output logic [NUM_RAILS-1:0] o_high_limit_fault,
  output logic [NUM_RAILS-1:0] o_high_limit_warn,
  output logic [NUM_RAILS-1:0] o_low_limit_warn,
  output logic [NUM_RAILS-1:0] o_low_limit_fault,
  output logic [NUM_RAILS-1:0] o_margin_low,
  output logic [NUM_RAILS-1:0] o_margin_high,
  output logic [NUM_GPI-1:0] o_gpi_asserted,
  output logic [NUM_GPI-1:0] o_gpi_fault,
  output logic o_latch_clear,
  output logic [2:0] o_pin_state
);

  // ==========================================================
  // configuration registers
  logic [NUM_GPI-1:0] gpi_polarity;
  logic [NUM_GPI-1:0] gpi_defined;
  logic [NUM_GPI-1:0] gpi_fault_en;
  logic [DATA_W-1:0] gpi_special;
  logic [NUM_RAILS-1:0] rail_sensed;
  logic [NUM_RAILS-1:0] rail_adaptive;
  logic [NUM_RAILS-1:0] rail_margin_en;
  logic [5:0] vin_select;
  logic [MV_W-1:0] setpoint [NUM_RAILS];
  logic [MV_W-1:0] ratio [NUM_RAILS*NUM_THR];
  logic [MV_W-1:0] limit [NUM_RAILS*NUM_THR];
  logic [NUM_RAILS-1:0] dir_up;
  logic [NUM_RAILS-1:0] seen_pg;

  wire [3:0] region = i_addr[11:8];
  wire [7:0] sub = i_addr[7:0];
  wire wr_polarity = i_wr_strobe && (i_addr == OFS_GPI_POLARITY);
  wire wr_defined = i_wr_strobe && (i_addr == OFS_GPI_DEFINED);
  wire wr_fault_en = i_wr_strobe && (i_addr == OFS_GPI_FAULT_EN);
  wire wr_special = i_wr_strobe && (i_addr == OFS_GPI_SPECIAL);
  wire wr_sensed = i_wr_strobe && (i_addr == OFS_RAIL_SENSED);
  wire wr_adaptive = i_wr_strobe && (i_addr == OFS_RAIL_ADAPTIVE);
  wire wr_margin_en = i_wr_strobe && (i_addr == OFS_RAIL_MARGIN_EN);
  wire wr_vin = i_wr_strobe && (i_addr == OFS_VIN_SELECT);
  wire hit_setpoint = (region == REGION_SETPOINT) && (sub < RAIL_LIMIT);
  wire hit_ratio = (region == REGION_RATIO) && (sub < SLOT_LIMIT);
  wire hit_limit = (region == REGION_LIMIT) && (sub < SLOT_LIMIT);
  wire wr_setpoint = i_wr_strobe && hit_setpoint;
  wire wr_ratio = i_wr_strobe && hit_ratio;
  wire [IDX_W-1:0] sp_idx = sub[IDX_W-1:0];
  wire [MV_W-1:0] new_sp = i_wr_data[MV_W-1:0];

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      gpi_polarity <= RST_VEC;
      gpi_defined <= RST_VEC;
      gpi_fault_en <= RST_VEC;
      gpi_special <= RST_WORD;
      rail_sensed <= RST_VEC;
      rail_adaptive <= RST_VEC;
      rail_margin_en <= RST_VEC;
      vin_select <= RST_VIN;
    end
    else
    begin
      if (wr_polarity) gpi_polarity <= i_wr_data[NUM_GPI-1:0]; // [RULE_14]
      if (wr_defined) gpi_defined <= i_wr_data[NUM_GPI-1:0];
      if (wr_fault_en) gpi_fault_en <= i_wr_data[NUM_GPI-1:0];
      if (wr_special) gpi_special <= i_wr_data;
      if (wr_sensed) rail_sensed <= i_wr_data[NUM_RAILS-1:0];
      if (wr_adaptive) rail_adaptive <= i_wr_data[NUM_RAILS-1:0];
      if (wr_margin_en) rail_margin_en <= i_wr_data[NUM_RAILS-1:0];
      if (wr_vin) vin_select <= i_wr_data[5:0];
    end
  end

  // the direction of the last setpoint move picks which limits jump and which creep
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      for (int i = 0; i < NUM_RAILS; i++)
      begin
        setpoint[i] <= RST_MV;
      end
      dir_up <= RST_VEC;
    end
    else if (wr_setpoint)
    begin
      setpoint[sp_idx] <= new_sp; // [RULE_21]
      dir_up[sp_idx] <= (new_sp > setpoint[sp_idx]);
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      for (int i = 0; i < NUM_RAILS*NUM_THR; i++)
      begin
        ratio[i] <= RST_MV;
      end
    end
    else if (wr_ratio)
    begin
      ratio[sub] <= i_wr_data[MV_W-1:0];
    end
  end

  // ==========================================================
  // step timer: one gradual step per limit per tick
  logic [31:0] tick_cnt;
  logic step_pend;
  logic step_scan;
  logic [SLOT_W-1:0] slot;

  wire tick = (tick_cnt == 32'(P_STEP_CYCLES - 1));
  wire scan_end = (slot == SLOT_LAST);
  // a tick on the last slot is carried straight into the next pass, never doubled
  wire next_pend = scan_end ? 1'b0 : (step_pend | tick);

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      tick_cnt <= RST_WORD;
      step_pend <= 1'b0;
      step_scan <= 1'b0;
      slot <= '0;
    end
    else
    begin
      tick_cnt <= tick ? RST_WORD : tick_cnt + 32'h0000_0001;
      step_pend <= next_pend;
      if (scan_end) step_scan <= step_pend | tick;
      slot <= scan_end ? '0 : slot + 8'h01;
    end
  end

  // ==========================================================
  // limit tracking, one (rail, limit) pair per cycle through a shared multiplier
  wire [IDX_W-1:0] scan_rail = slot[7:3];
  wire [2:0] scan_sel = slot[2:0];
  wire [31:0] product = setpoint[scan_rail] * ratio[slot];
  wire product_sat = |product[31:RATIO_FRAC+MV_W];
  wire [MV_W-1:0] target = product_sat ? 16'hffff : product[RATIO_FRAC+MV_W-1:RATIO_FRAC];
  wire [MV_W-1:0] cur = limit[slot];
  wire sel_high = (scan_sel == THR_HIGH_FAULT) || (scan_sel == THR_HIGH_WARN);
  wire sel_low_pg = scan_sel[2];
  // rising setpoint: high limits jump; falling setpoint: low and power-good limits jump
  wire immediate = !rail_adaptive[scan_rail] ||
    (dir_up[scan_rail] ? sel_high : sel_low_pg); // [RULE_02] [RULE_03]
  wire [MV_W-1:0] gap_up = target - cur;
  wire [MV_W-1:0] gap_down = cur - target;
  wire [MV_W-1:0] stepped_up = (gap_up <= STEP_MV) ? target : cur + STEP_MV; // [RULE_22]
  wire [MV_W-1:0] stepped_down = (gap_down <= STEP_MV) ? target : cur - STEP_MV; // [RULE_22]

  logic [MV_W-1:0] next_limit;
  always_comb
  begin
    if (immediate)
      next_limit = target;
    else if (step_scan && (cur < target))
      next_limit = stepped_up; // [RULE_01]
    else if (step_scan && (cur > target))
      next_limit = stepped_down; // [RULE_04]
    else
      next_limit = cur;
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      for (int i = 0; i < NUM_RAILS*NUM_THR; i++)
      begin
        limit[i] <= RST_MV;
      end
    end
    else
    begin
      limit[slot] <= next_limit; // [RULE_21]
    end
  end

  // ==========================================================
  // general inputs
  logic [NUM_GPI-1:0] gpi_s1;
  logic [NUM_GPI-1:0] gpi_s2;

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      gpi_s1 <= RST_VEC;
      gpi_s2 <= RST_VEC;
    end
    else
    begin
      gpi_s1 <= i_general_input_pin;
      gpi_s2 <= gpi_s1;
    end
  end

  wire [NUM_GPI-1:0] gpi_now = (gpi_s2 ^ gpi_polarity) & gpi_defined; // [RULE_14] [RULE_15]
  wire [IDX_W-1:0] clr_idx = gpi_special[SP_CLR_IDX +: IDX_W];
  wire [IDX_W-1:0] men_idx = gpi_special[SP_MEN_IDX +: IDX_W];
  wire [IDX_W-1:0] mlow_idx = gpi_special[SP_MLOW_IDX +: IDX_W];
  wire clr_ok = gpi_special[SP_CLR_EN] && (clr_idx < IDX_W'(NUM_GPI));
  wire men_ok = gpi_special[SP_MEN_EN] && (men_idx < IDX_W'(NUM_GPI));
  wire mlow_ok = gpi_special[SP_MLOW_EN] && (mlow_idx < IDX_W'(NUM_GPI));
  wire clr_rise = clr_ok && gpi_now[clr_idx] && !o_gpi_asserted[clr_idx]; // [RULE_18]
  wire margin_on = men_ok && gpi_now[men_idx]; // [RULE_19]
  wire margin_lo = mlow_ok && gpi_now[mlow_idx]; // [RULE_20]
  wire [NUM_GPI-1:0] fault_fall = gpi_fault_en & o_gpi_asserted & ~gpi_now; // [RULE_17]

  logic [2:0] next_pin_state;
  logic [1:0] pin_cnt;
  always_comb
  begin
    next_pin_state = 3'h0;
    pin_cnt = 2'h0;
    for (int i = 0; i < NUM_GPI; i++)
    begin
      if (gpi_defined[i] && (pin_cnt != 2'h3))
      begin
        next_pin_state[pin_cnt] = gpi_now[i]; // [RULE_16]
        pin_cnt = pin_cnt + 2'h1;
      end
    end
  end

  // ==========================================================
  // per-rail power good and limit comparisons
  logic [NUM_RAILS-1:0] below_off;
  logic [NUM_RAILS-1:0] next_pg;
  logic [NUM_RAILS-1:0] next_mask;
  logic [NUM_RAILS-1:0] next_hf;
  logic [NUM_RAILS-1:0] next_hw;
  logic [NUM_RAILS-1:0] next_lw;
  logic [NUM_RAILS-1:0] next_lf;

  wire [IDX_W-1:0] vin_idx = vin_select[VIN_IDX +: IDX_W];
  wire vin_ok = vin_select[VIN_EN] && (vin_idx < IDX_W'(NUM_RAILS));
  wire vin_fail = vin_ok && below_off[vin_idx]; // [RULE_13]

  genvar r;
  generate
    for (r = 0; r < NUM_RAILS; r++)
    begin : g_rail
      wire [MV_W-1:0] v = i_sense_mv[r*MV_W +: MV_W];
      wire above_on = v > limit[r*NUM_THR + int'(THR_PG_ON)];
      wire is_vin = vin_ok && (vin_idx == IDX_W'(r));
      assign below_off[r] = v < limit[r*NUM_THR + int'(THR_PG_OFF)];
      // a fault only drops power good when its response turns the rail off
      assign next_pg[r] = i_fault_off[r] ? 1'b0 : // [RULE_10]
        rail_sensed[r] ? (above_on ? 1'b1 : (below_off[r] ? 1'b0 : o_power_good[r])) : // [RULE_05] [RULE_06] [RULE_07]
        (i_turn_on_met[r] ? 1'b1 : (i_turn_off_met[r] ? 1'b0 : o_power_good[r])); // [RULE_08] [RULE_09]
      assign next_mask[r] = !i_rail_on[r] || !seen_pg[r] || (vin_fail && !is_vin); // [RULE_11] [RULE_12] [RULE_13]
      assign next_hf[r] = rail_sensed[r] && (v > limit[r*NUM_THR + int'(THR_HIGH_FAULT)]);
      assign next_hw[r] = rail_sensed[r] && (v > limit[r*NUM_THR + int'(THR_HIGH_WARN)]);
      assign next_lw[r] = rail_sensed[r] && !next_mask[r] &&
        (v < limit[r*NUM_THR + int'(THR_LOW_WARN)]); // [RULE_11]
      assign next_lf[r] = rail_sensed[r] && !next_mask[r] &&
        (v < limit[r*NUM_THR + int'(THR_LOW_FAULT)]); // [RULE_11]
    end
  endgenerate

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_power_good <= RST_VEC;
      seen_pg <= RST_VEC;
      o_low_limit_mask <= {NUM_RAILS{1'b1}};
      o_high_limit_fault <= RST_VEC;
      o_high_limit_warn <= RST_VEC;
      o_low_limit_warn <= RST_VEC;
      o_low_limit_fault <= RST_VEC;
    end
    else
    begin
      o_power_good <= next_pg;
      // first power good of a start-up is remembered until the rail is off again
      seen_pg <= (seen_pg & i_rail_on) | o_power_good; // [RULE_12]
      o_low_limit_mask <= next_mask;
      o_high_limit_fault <= next_hf;
      o_high_limit_warn <= next_hw;
      o_low_limit_warn <= next_lw;
      o_low_limit_fault <= next_lf;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_gpi_asserted <= RST_VEC;
      o_gpi_fault <= RST_VEC;
      o_latch_clear <= 1'b0;
      o_pin_state <= 3'h0;
      o_margin_low <= RST_VEC;
      o_margin_high <= RST_VEC;
    end
    else
    begin
      o_gpi_asserted <= gpi_now; // [RULE_15]
      o_gpi_fault <= fault_fall; // [RULE_17]
      o_latch_clear <= clr_rise; // [RULE_18]
      o_pin_state <= next_pin_state; // [RULE_16]
      o_margin_low <= rail_margin_en & {NUM_RAILS{margin_on && margin_lo}}; // [RULE_19] [RULE_20]
      o_margin_high <= rail_margin_en & {NUM_RAILS{margin_on && !margin_lo}}; // [RULE_19] [RULE_20]
    end
  end

  // ==========================================================
  // register read port
  logic [DATA_W-1:0] rd_mux;
  always_comb
  begin
    if (i_addr == OFS_GPI_POLARITY)
      rd_mux = {8'h00, gpi_polarity};
    else if (i_addr == OFS_GPI_DEFINED)
      rd_mux = {8'h00, gpi_defined};
    else if (i_addr == OFS_GPI_FAULT_EN)
      rd_mux = {8'h00, gpi_fault_en};
    else if (i_addr == OFS_GPI_SPECIAL)
      rd_mux = gpi_special;
    else if (i_addr == OFS_RAIL_SENSED)
      rd_mux = {8'h00, rail_sensed};
    else if (i_addr == OFS_RAIL_ADAPTIVE)
      rd_mux = {8'h00, rail_adaptive};
    else if (i_addr == OFS_RAIL_MARGIN_EN)
      rd_mux = {8'h00, rail_margin_en};
    else if (i_addr == OFS_VIN_SELECT)
      rd_mux = {26'h000_0000, vin_select};
    else if (i_addr == OFS_POWER_GOOD)
      rd_mux = {8'h00, o_power_good};
    else if (i_addr == OFS_GPI_STATE)
      rd_mux = {8'h00, o_gpi_asserted};
    else if (i_addr == OFS_LOW_MASK)
      rd_mux = {8'h00, o_low_limit_mask};
    else if (hit_setpoint)
      rd_mux = {16'h0000, setpoint[sp_idx]};
    else if (hit_ratio)
      rd_mux = {16'h0000, ratio[sub]};
    else if (hit_limit)
      rd_mux = {16'h0000, limit[sub]};
    else
      rd_mux = RST_WORD;
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_rd_data <= RST_WORD;
    else
      o_rd_data <= i_rd_strobe ? rd_mux : RST_WORD;
  end

endmodule

`default_nettype wire

/* File: common/rail_pg_pkg.sv */
// constants and types shared by the rail power-good and general input controller
//
// Summary of operation
// [RULE_01] setpoint rise: low, margin, power-good limits hold, then climb 20 mV per 400 us
// [RULE_02] setpoint rise: high limit warn and fault move to new values at once
// [RULE_03] setpoint fall: low limit warn, fault and both power-good limits move at once
// [RULE_04] setpoint fall: high limit and margin limits hold, then drop 20 mV per 400 us
// [RULE_05] sensed rail: power good sets when voltage is above power-good-on
// [RULE_06] sensed rail: power good clears when voltage is below power-good-off
// [RULE_07] sensed rail between the two power-good limits keeps its status
// [RULE_08] unsensed rail: power good sets the cycle after all turn-on conditions hold
// [RULE_09] unsensed rail: power good clears once all turn-off conditions hold
// [RULE_10] warnings and faults leave power good alone unless the fault turns the rail off
// [RULE_11] low limit warnings and faults are masked while the rail is off
// [RULE_12] low limit checks are masked at startup until first power good
// [RULE_13] input-supply rail below power-good-off masks low limit checks on other rails
// [RULE_14] all 24 pins usable as general inputs with selectable polarity
// [RULE_15] any general input, after polarity, feeds sequencing dependencies
// [RULE_16] the first three defined general inputs feed the pin-selected state
// [RULE_17] fault-enabled input deassertion is a fault event able to shut rails down
// [RULE_18] the latch-clear input clears sticky latched statuses of general outputs
// [RULE_19] asserted margin enable input margins every margin-enabled rail
// [RULE_20] low/not-high input selects margin low when asserted, high when deasserted
// [RULE_21] adaptive mode keeps all limits at fixed ratios of the current setpoint
// [RULE_22] a gradual step that would pass its target clamps to the target and stops
package rail_pg_pkg;

  localparam int NUM_RAILS = 24;
  localparam int NUM_GPI = 24;
  localparam int NUM_THR = 8;
  localparam int MV_W = 16;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 5;
  localparam int SLOT_W = 8;
  localparam int RATIO_FRAC = 14;

  // scan covers every (rail, limit) pair once per pass
  localparam logic [SLOT_W-1:0] SLOT_LAST = 8'hbf;
  localparam logic [7:0] RAIL_LIMIT = 8'h18;
  localparam logic [7:0] SLOT_LIMIT = 8'hc0;

  // gradual limit motion
  localparam logic [MV_W-1:0] STEP_MV = 16'h0014;
  localparam int STEP_TIME_US = 400;
  localparam int CLK_PERIOD_NS = 20;
  localparam int STEP_CYCLES = (STEP_TIME_US * 1000) / CLK_PERIOD_NS;

  // register word addresses
  localparam logic [ADDR_W-1:0] OFS_GPI_POLARITY = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_GPI_DEFINED = 12'h001;
  localparam logic [ADDR_W-1:0] OFS_GPI_FAULT_EN = 12'h002;
  localparam logic [ADDR_W-1:0] OFS_GPI_SPECIAL = 12'h003;
  localparam logic [ADDR_W-1:0] OFS_RAIL_SENSED = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_RAIL_ADAPTIVE = 12'h005;
  localparam logic [ADDR_W-1:0] OFS_RAIL_MARGIN_EN = 12'h006;
  localparam logic [ADDR_W-1:0] OFS_VIN_SELECT = 12'h007;
  localparam logic [ADDR_W-1:0] OFS_POWER_GOOD = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_GPI_STATE = 12'h009;
  localparam logic [ADDR_W-1:0] OFS_LOW_MASK = 12'h00a;
  localparam logic [3:0] REGION_SETPOINT = 4'h1;
  localparam logic [3:0] REGION_RATIO = 4'h2;
  localparam logic [3:0] REGION_LIMIT = 4'h3;

  // field positions in the special-input and supply-select words
  localparam int SP_CLR_IDX = 0;
  localparam int SP_CLR_EN = 5;
  localparam int SP_MEN_IDX = 8;
  localparam int SP_MEN_EN = 13;
  localparam int SP_MLOW_IDX = 16;
  localparam int SP_MLOW_EN = 21;
  localparam int VIN_IDX = 0;
  localparam int VIN_EN = 5;

  // values after reset
  localparam logic [NUM_GPI-1:0] RST_VEC = 24'h00_0000;
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [MV_W-1:0] RST_MV = 16'h0000;
  localparam logic [5:0] RST_VIN = 6'h00;

  typedef enum logic [2:0] {
    THR_HIGH_FAULT = 3'b000,
    THR_HIGH_WARN = 3'b001,
    THR_MARGIN_HIGH = 3'b010,
    THR_MARGIN_LOW = 3'b011,
    THR_LOW_WARN = 3'b100,
    THR_LOW_FAULT = 3'b101,
    THR_PG_ON = 3'b110,
    THR_PG_OFF = 3'b111
  } thr_sel_t;

endpackage

/* File: testbench/rail_pg_monitor.sv */
// concurrent checks on the rail power-good controller ports
`timescale 1ns/100ps
`default_nettype none
module rail_pg_monitor
  import rail_pg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_rd_strobe,
  input wire logic [DATA_W-1:0] o_rd_data,
  input wire logic [NUM_RAILS-1:0] i_rail_on,
  input wire logic [NUM_RAILS-1:0] i_fault_off,
  input wire logic [NUM_RAILS-1:0] o_power_good,
  input wire logic [NUM_RAILS-1:0] o_low_limit_mask,
  input wire logic [NUM_RAILS-1:0] o_low_limit_warn,
  input wire logic [NUM_RAILS-1:0] o_low_limit_fault,
  input wire logic [NUM_RAILS-1:0] o_margin_low,
  input wire logic [NUM_RAILS-1:0] o_margin_high,
  input wire logic [NUM_GPI-1:0] o_gpi_asserted,
  input wire logic [NUM_GPI-1:0] o_gpi_fault,
  input wire logic o_latch_clear
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  logic [NUM_RAILS-1:0] seen;
  // ==========
  // rails with power good since switched on
  always_ff @(posedge i_mclk or posedge i_sys_rst)
    if (i_sys_rst)
      seen <= '0;
    else
      seen <= (seen | o_power_good) & i_rail_on;
  // ==========
  // properties
  property p_rd_idle;
    !$past(i_rd_strobe) |-> o_rd_data == '0;
  endproperty
  property p_fault_off;
    |i_fault_off |=> (o_power_good & $past(i_fault_off)) == '0;
  endproperty
  property p_off_mask;
    (~$past(i_rail_on) & ~$past(i_rail_on, 2) & ~o_low_limit_mask) == '0;
  endproperty
  // one cycle of slack: the warn register loads from the same next_mask as the mask
  property p_warn_masked;
    ((o_low_limit_warn | o_low_limit_fault) & o_low_limit_mask & $past(o_low_limit_mask)) == '0;
  endproperty
  property p_start_mask;
    (~o_low_limit_mask & ~seen & ~$past(o_power_good)) == '0;
  endproperty
  property p_fault_pulse;
    (o_gpi_fault & ($past(o_gpi_fault) | o_gpi_asserted)) == '0;
  endproperty
  property p_clear_pulse;
    o_latch_clear |=> !o_latch_clear;
  endproperty
  property p_margin_dir;
    !(|o_margin_low && |o_margin_high);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  a_fault_off: assert property (p_fault_off) else $error("power good kept on fault off");
  a_off_mask: assert property (p_off_mask) else $error("off rail unmasked");
  a_warn_masked: assert property (p_warn_masked) else $error("low limit event while masked");
  a_start_mask: assert property (p_start_mask) else $error("early unmask");
  a_fault_pulse: assert property (p_fault_pulse) else $error("bad fault pulse");
  a_clear_pulse: assert property (p_clear_pulse) else $error("latch clear too long");
  a_margin_dir: assert property (p_margin_dir) else $error("margin both ways");
  c_fault: cover property (|o_gpi_fault);
  c_clear: cover property (o_latch_clear);
  c_mlow: cover property (|o_margin_low);
  c_pg_drop: cover property (|(~o_power_good & $past(o_power_good)));
endmodule
`default_nettype wire

/* File: testbench/rail_sense_model.sv */
// regulator model: sensed rail voltages slew toward commanded levels
`timescale 1ns/100ps
`default_nettype none
module rail_sense_model
  import rail_pg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic [NUM_RAILS*MV_W-1:0] i_cmd_mv,
  input wire logic [MV_W-1:0] i_slew_mv,
  output logic [NUM_RAILS*MV_W-1:0] o_sense_mv
);
  initial o_sense_mv = '0;
  // a slow slew walks through the hysteresis band instead of jumping over it
  always @(posedge i_mclk)
    for (int r = 0; r < NUM_RAILS; r++)
    begin
      logic [MV_W-1:0] c;
      logic [MV_W-1:0] s;
      c = i_cmd_mv[r*MV_W +: MV_W];
      s = o_sense_mv[r*MV_W +: MV_W];
      if (i_slew_mv == '0 || (c > s ? c - s : s - c) <= i_slew_mv)
        s = c;
      else if (c > s)
        s = s + i_slew_mv;
      else
        s = s - i_slew_mv;
      o_sense_mv[r*MV_W +: MV_W] <= s;
    end
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the rail power-good controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import rail_pg_pkg::*;
  localparam int unsigned STEP = 400;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [NUM_RAILS*MV_W-1:0] cmd = '0;
  logic [MV_W-1:0] slew = '0;
  logic [NUM_RAILS-1:0] on = '0, ton = '0, toff = '0, foff = '0;
  logic [NUM_GPI-1:0] pins = '0;
  logic [NUM_RAILS*MV_W-1:0] sense;
  logic [DATA_W-1:0] rdata, d, pol;
  logic [NUM_RAILS-1:0] pg, lmask, lw, lf, mlo, mhi, hf, hw;
  logic [NUM_GPI-1:0] gasr, gflt;
  logic lclr, e;
  logic [2:0] pstate;
  logic [15:0] rt [8] = '{16'h4c00, 16'h4800, 16'h4400, 16'h3c00, 16'h3a00, 16'h3600, 16'h3c00, 16'h3800};
  int vt [6] = '{1000, 937, 874, 937, 938, 900};
  int n_errors = 0, tests_run = 0, seed = 10013, v;

  always #10 mclk = ~mclk;

  rail_power_good_ctrl #(.P_STEP_CYCLES(STEP)) rail_power_good_ctrl_inst (
    .i_mclk(mclk), .i_sys_rst(rst), .i_addr(addr), .i_wr_data(wdata), .i_wr_strobe(wr), .i_rd_strobe(rd),
    .o_rd_data(rdata), .i_sense_mv(sense), .i_rail_on(on), .i_turn_on_met(ton), .i_turn_off_met(toff),
    .i_fault_off(foff), .i_general_input_pin(pins), .o_power_good(pg), .o_low_limit_mask(lmask),
    .o_high_limit_fault(hf), .o_high_limit_warn(hw), .o_low_limit_warn(lw), .o_low_limit_fault(lf),
    .o_margin_low(mlo), .o_margin_high(mhi), .o_gpi_asserted(gasr), .o_gpi_fault(gflt),
    .o_latch_clear(lclr), .o_pin_state(pstate));
  rail_sense_model rail_sense_model_inst (.i_mclk(mclk), .i_cmd_mv(cmd), .i_slew_mv(slew), .o_sense_mv(sense));

  // ==========
  // shared tasks
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wrw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] val);
    @(posedge mclk);
    addr <= a;
    wdata <= val;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rdw(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] val);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 val = rdata;
  endtask
  function automatic logic [15:0] tgt(input int sp, input int k);
    return 16'((sp * rt[k]) >> 14);
  endfunction
  task automatic lim_all(input int sp);
    for (int k = 0; k < 8; k++)
    begin
      rdw(12'h300 + 12'(k), d);
      chk("limit settled", d, tgt(sp, k));
    end
  endtask
  task automatic limits(input int old, input int nw);
    logic [15:0] o;
    wrw(12'h100, nw);
    cyc(200);
    for (int k = 0; k < 8; k++)
    begin
      rdw(12'h300 + 12'(k), d);
      o = tgt(old, k);
      if (nw > old ? k < 2 : k > 3)
        chk("limit jump", d, tgt(nw, k));
      else
        chk("limit held", d === o || d === (nw > old ? o + STEP_MV : o - STEP_MV), 1);
    end
    cyc(5 * STEP);
    lim_all(nw);
  endtask
  task automatic setv(input int r, input int val);
    int i = 0;
    @(posedge mclk);
    cmd[r*MV_W +: MV_W] <= 16'(val);
    while (sense[r*MV_W +: MV_W] !== 16'(val) && i < 200)
    begin
      @(posedge mclk);
      i++;
    end
    if (i == 200)
    begin
      $display("sense timeout");
      n_errors++;
      summarize();
    end
    cyc(5);
    #1;
  endtask
  task automatic pulse(input int b, input logic fire);
    int c = 0;
    @(posedge mclk);
    pins[b] <= pol[b] ^ ~fire;
    cyc(6);
    @(posedge mclk);
    pins[b] <= pol[b] ^ fire;
    repeat (6)
    begin
      @(posedge mclk);
      #1 c += (b == 4) ? gflt[4] : lclr;
    end
    chk("pulse count", c, 1);
  endtask

  initial
  begin
    #(20000 * 20);
    $display("timeout");
    n_errors++;
    summarize();
  end

  // ==========
  // main sequence
  initial
  begin
    cyc(5);
    rst <= 1'b0;
    for (int a = 0; a < 12; a++)
    begin
      rdw(a == 11 ? 12'h0ff : 12'(a), d);
      chk("reset word", d, a == 10 ? 32'h00ff_ffff : 32'h0000_0000);
    end
    wrw(12'h008, 32'hffff_ffff);
    rdw(12'h008, d);
    chk("read-only word", d, 32'h0000_0000);
    $display("done registers");
    pol = $random(seed);
    wrw(12'h000, pol);
    rdw(12'h000, d);
    chk("polarity", d, {8'h00, pol[23:0]});
    wrw(12'h001, 32'h00ff_ffff);
    wrw(12'h002, 32'h0000_0010);
    wrw(12'h003, 32'h0027_2625);
    wrw(12'h006, 32'h0000_0003);
    repeat (12)
    begin
      @(posedge mclk);
      pins <= 24'($random(seed));
      cyc(4);
      #1 chk("asserted", gasr, pins ^ pol[23:0]);
      chk("pin state", pstate, 3'(pins ^ pol[23:0]));
    end
    pulse(4, 1'b0);
    pulse(5, 1'b1);
    for (int lo = 0; lo < 2; lo++)
    begin
      @(posedge mclk);
      pins[6] <= ~pol[6];
      pins[7] <= pol[7] ^ lo[0];
      cyc(5);
      #1 chk("margin low", mlo, lo ? 24'h00_0003 : 24'h00_0000);
      chk("margin high", mhi, lo ? 24'h00_0000 : 24'h00_0003);
    end
    @(posedge mclk);
    pins[6] <= pol[6];
    cyc(5);
    #1 chk("margin off", mlo | mhi, 24'h00_0000);
    $display("done inputs");
    for (int r = 0; r < 4; r++)
    begin
      wrw(12'h100 + 12'(r), 1000);
      for (int k = 0; k < 8; k++)
        wrw(12'h200 + 12'(r * 8 + k), {16'h0000, rt[k]});
    end
    cyc(400);
    lim_all(1000);
    wrw(12'h005, 32'h0000_0001);
    limits(1000, 1030);
    limits(1030, 985);
    $display("done limits");
    wrw(12'h004, 32'h0000_000a);
    slew <= 16'h000a;
    on <= 24'h00_000e;
    setv(3, 1000);
    chk("startup mask", lmask[1], 1'b1);
    e = 1'b0;
    for (int i = 0; i < 26; i++)
    begin
      v = i < 6 ? vt[i] : 800 + int'($unsigned($random(seed)) % 400);
      setv(1, v);
      e = v > tgt(1000, 6) ? 1'b1 : v < tgt(1000, 7) ? 1'b0 : e;
      chk("power good", pg[1], e);
      chk("low warn", lw[1], v < tgt(1000, 4));
      chk("low fault", lf[1], v < tgt(1000, 5));
      chk("high limits", {hf[1], hw[1]}, {v > tgt(1000, 0), v > tgt(1000, 1)});
    end
    setv(1, 1000);
    foff[1] <= 1'b1;
    cyc(2);
    #1 chk("fault off", pg[1], 1'b0);
    foff[1] <= 1'b0;
    on[1] <= 1'b0;
    cyc(3);
    #1 chk("off mask", lmask[1], 1'b1);
    on[1] <= 1'b1;
    cyc(4);
    #1 chk("rearmed mask", lmask[1], 1'b0);
    wrw(12'h007, 32'h0000_0023);
    setv(1, 850);
    setv(3, 800);
    chk("supply mask", lw[1], 1'b0);
    setv(3, 1000);
    chk("supply back", lw[1], 1'b1);
    @(posedge mclk);
    ton[2] <= 1'b1;
    @(posedge mclk);
    #1 chk("unsensed on", pg[2], 1'b1);
    ton[2] <= 1'b0;
    toff[2] <= 1'b1;
    @(posedge mclk);
    #1 chk("unsensed off", pg[2], 1'b0);
    $display("done power good");
    summarize();
  end
endmodule

bind rail_power_good_ctrl rail_pg_monitor rail_pg_monitor_inst (.*);
`default_nettype wire
